// ===== logic/tgpa_pkg.sv
// Constants and types for the transmit-gate, clock-phase and amplitude pin block
package tgpa_pkg;

  localparam int CLK_PERIOD_NS     = 10;
  // Filter time on both gate and amplitude inputs; least time, so round up
  localparam int FILTER_TIME_NS    = 625;
  localparam int FILTER_CYCLES     = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_CNT_W      = 7;
  localparam int FRAME_W           = 64;

  // Pull-ups on both pins mean a lost pin reads high
  localparam logic GATE_RESET_LEVEL  = 1'b1;
  localparam logic LEVEL_RESET_LEVEL = 1'b1;
  localparam logic APPLIED_RESET     = 1'b0;
  localparam logic ROLE_SLAVE        = 1'b0;
  localparam logic LEVEL_LOW_SWING   = 1'b0;
  localparam logic LEVEL_HIGH_SWING  = 1'b1;

  // Device operating state, driven by the device state machine elsewhere
  typedef enum logic [4:0] {
    TGPA_POWERUP = 5'h01,
    TGPA_CONFIG  = 5'h02,
    TGPA_NORMAL  = 5'h04,
    TGPA_STANDBY = 5'h08,
    TGPA_WAKEUP  = 5'h10
  } tgpa_state_t;

  // Completed frame from the serial-in shifter
  typedef struct packed {
    logic               valid;
    logic [FRAME_W-1:0] data;
  } tgpa_frame_t;

  // Isolated link transmitter events, one-cycle pulses
  typedef struct packed {
    logic tx_start;
    logic tx_done;
  } tgpa_link_evt_t;

endpackage

// ===== logic/tgpa_pins.sv
// Gate/phase and amplitude pin sampling, filtering and application
`timescale 1ns/1ns
`default_nettype none
module tgpa_pins (
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  input  wire tgpa_pkg::tgpa_state_t  DEV_STATE,
  input  wire logic                   ROLE_SELECT_PIN,
  input  wire logic                   GATE_PHASE_PIN,
  input  wire logic                   TX_LEVEL_SELECT_PIN,
  input  wire logic                   CHIP_SELECT_N,
  input  wire tgpa_pkg::tgpa_frame_t  SERIAL_FRAME,
  input  wire tgpa_pkg::tgpa_link_evt_t LINK_EVT,
  output var  tgpa_pkg::tgpa_frame_t  TX_QUEUE_PUSH,
  output var  logic                   RX_SHIFT_EN,
  output var  logic                   MASTER_ROLE,
  output var  logic                   CLOCK_PHASE,
  output var  logic                   GATE_LATCHED,
  output var  logic                   GATE_PULLUP_EN,
  output var  logic                   TX_LEVEL
);

  // Stability counter step: restart when input equals accepted level or on the last count, else count
  function automatic logic [tgpa_pkg::FILTER_CNT_W-1:0] filt_next_cnt(
    input logic                            sync_in,
    input logic                            accepted,
    input logic [tgpa_pkg::FILTER_CNT_W-1:0] cnt
  );
    logic last;
    last = (cnt == tgpa_pkg::FILTER_CNT_W'(tgpa_pkg::FILTER_CYCLES - 1));
    if (sync_in == accepted || last) begin
      filt_next_cnt = '0;
    end else begin
      filt_next_cnt = cnt + 1'b1;
    end
  endfunction

  // Accept the new level only after a full stable run
  function automatic logic filt_next_level(
    input logic                            sync_in,
    input logic                            accepted,
    input logic [tgpa_pkg::FILTER_CNT_W-1:0] cnt
  );
    if (sync_in != accepted && cnt == tgpa_pkg::FILTER_CNT_W'(tgpa_pkg::FILTER_CYCLES - 1)) begin
      filt_next_level = sync_in;
    end else begin
      filt_next_level = accepted;
    end
  endfunction

  // Two-stage synchronisers for the pins
  logic                            role_s1,  role_s2;
  logic                            gate_s1,  gate_s2;
  logic                            level_s1, level_s2;
  logic                            cs_s1,    cs_s2, cs_prev;
  logic [tgpa_pkg::FILTER_CNT_W-1:0] gate_cnt, level_cnt;
  logic                            gate_filt, level_filt;
  logic                            level_pending;
  logic                            slave_role;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      role_s1  <= 1'b0;
      role_s2  <= 1'b0;
      gate_s1  <= tgpa_pkg::GATE_RESET_LEVEL;
      gate_s2  <= tgpa_pkg::GATE_RESET_LEVEL;
      level_s1 <= tgpa_pkg::LEVEL_RESET_LEVEL;
      level_s2 <= tgpa_pkg::LEVEL_RESET_LEVEL;
      cs_s1    <= 1'b1;
      cs_s2    <= 1'b1;
      cs_prev  <= 1'b1;
    end else begin
      role_s1  <= ROLE_SELECT_PIN;
      role_s2  <= role_s1;
      gate_s1  <= GATE_PHASE_PIN;
      gate_s2  <= gate_s1;
      level_s1 <= TX_LEVEL_SELECT_PIN;
      level_s2 <= level_s1;
      cs_s1    <= CHIP_SELECT_N;
      cs_s2    <= cs_s1;
      cs_prev  <= cs_s2;
    end
  end

  // Decoded conditions
  wire st_normal  = (DEV_STATE == tgpa_pkg::TGPA_NORMAL);
  wire st_config  = (DEV_STATE == tgpa_pkg::TGPA_CONFIG);
  wire st_standby = (DEV_STATE == tgpa_pkg::TGPA_STANDBY);
  wire st_capture = (DEV_STATE == tgpa_pkg::TGPA_WAKEUP) || (DEV_STATE == tgpa_pkg::TGPA_POWERUP);
  wire cs_fall    = cs_prev && !cs_s2;
  wire slave_norm = slave_role && st_normal;
  wire master_norm = !slave_role && st_normal;

  wire [tgpa_pkg::FILTER_CNT_W-1:0] next_gate_cnt   = filt_next_cnt(gate_s2, gate_filt, gate_cnt);
  wire                            next_gate_filt  = filt_next_level(gate_s2, gate_filt, gate_cnt);
  wire [tgpa_pkg::FILTER_CNT_W-1:0] next_level_cnt  = filt_next_cnt(level_s2, level_filt, level_cnt);
  wire                            next_level_filt = filt_next_level(level_s2, level_filt, level_cnt);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      gate_cnt   <= '0;
      gate_filt  <= tgpa_pkg::GATE_RESET_LEVEL;
      level_cnt  <= '0;
      level_filt <= tgpa_pkg::LEVEL_RESET_LEVEL;
    end else begin
      gate_cnt   <= next_gate_cnt;
      gate_filt  <= next_gate_filt;
      level_cnt  <= next_level_cnt;
      level_filt <= next_level_filt;
    end
  end

  // role and phase straps latched only in the configuration state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      slave_role  <= tgpa_pkg::ROLE_SLAVE;
      MASTER_ROLE <= 1'b0;
      CLOCK_PHASE <= 1'b0;
    end else if (st_config) begin
      slave_role  <= (role_s2 == tgpa_pkg::ROLE_SLAVE);
      MASTER_ROLE <= (role_s2 != tgpa_pkg::ROLE_SLAVE);
      // phase steers first or second serial clock sampling
      CLOCK_PHASE <= role_s2 ? gate_s2 : 1'b0;
    end
  end

  // gate captured at assertion and held for the frame
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      GATE_LATCHED <= tgpa_pkg::GATE_RESET_LEVEL;
    end else if (slave_role && cs_fall) begin
      GATE_LATCHED <= gate_filt;
    end
  end

  // push frame only when gate was latched high
  wire push_ok = slave_norm && SERIAL_FRAME.valid && GATE_LATCHED;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_QUEUE_PUSH <= '0;
    end else begin
      TX_QUEUE_PUSH.valid <= push_ok;
      // Data is discarded, not forwarded, when the gate is low
      TX_QUEUE_PUSH.data  <= push_ok ? SERIAL_FRAME.data : '0;
    end
  end

  // receive shifting runs on every chip-select period in slave role and normal state, regardless of gate
  // pull-up off in standby to meet low quiescent current
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RX_SHIFT_EN    <= 1'b0;
      GATE_PULLUP_EN <= 1'b0;
    end else begin
      RX_SHIFT_EN    <= slave_norm && !cs_s2;
      GATE_PULLUP_EN <= (st_config || st_normal) && !st_standby;
    end
  end

  // pending amplitude: latest capture wins, no per-frame copy
  // Power-up and wakeup captures also count as the latest setting, so a
  // link done before the first frame never brings back a stale level
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      level_pending <= tgpa_pkg::APPLIED_RESET;
    end else if (st_capture) begin
      level_pending <= level_filt;
    end else if (slave_norm && cs_fall) begin
      level_pending <= level_filt;
    end else if (master_norm) begin
      level_pending <= level_filt;
    end
  end

  // applied level: 0 low swing, 1 high swing
  // apply per role, or capture in wakeup and power-up
  wire slave_apply  = slave_norm && LINK_EVT.tx_done;
  wire master_apply = master_norm && LINK_EVT.tx_start;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_LEVEL <= tgpa_pkg::APPLIED_RESET;
    end else if (st_capture) begin
      TX_LEVEL <= level_filt;
    end else if (slave_apply || master_apply) begin
      TX_LEVEL <= level_pending;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_slave_assert;
    slave_role && cs_fall;
  endsequence

  sequence s_gated_frame;
    slave_norm && SERIAL_FRAME.valid && GATE_LATCHED;
  endsequence

  a_push_gate_high: assert property (s_gated_frame |=> TX_QUEUE_PUSH.valid &&
    TX_QUEUE_PUSH.data == $past(SERIAL_FRAME.data))
    else $error("gated frame not pushed");

  a_no_push_low: assert property ((!GATE_LATCHED || !slave_norm) |=>
    !TX_QUEUE_PUSH.valid && TX_QUEUE_PUSH.data == '0)
    else $error("frame pushed with gate low");

  a_gate_capture_hold: assert property (s_slave_assert |=>
    GATE_LATCHED == $past(gate_filt) ##1 (!cs_fall throughout $stable(GATE_LATCHED)[*2]))
    else $error("gate capture or hold wrong");

  a_phase_strap_fixed: assert property (!st_config |=> $stable(CLOCK_PHASE) &&
    $stable(MASTER_ROLE))
    else $error("phase strap changed outside config");

  a_pullup_state: assert property (st_standby |=> !GATE_PULLUP_EN)
    else $error("pull-up on in standby");

  a_level_slave_hold: assert property (slave_norm && !LINK_EVT.tx_done |=>
    $stable(TX_LEVEL))
    else $error("slave level changed before link done");

  a_level_master_apply: assert property (master_norm ##1 master_apply |=>
    TX_LEVEL == $past(level_filt, 2))
    else $error("master level not applied at link start");

  a_wake_capture: assert property (st_capture |=> TX_LEVEL == $past(level_filt))
    else $error("level not captured in wakeup");

  a_pending_capture: assert property (st_capture |=>
    level_pending == $past(level_filt))
    else $error("pending level not captured");

  a_filter_settle: assert property ($changed(gate_filt) |->
    $past(gate_s2) != $past(gate_filt) &&
    $past(gate_cnt) == tgpa_pkg::FILTER_CNT_W'(tgpa_pkg::FILTER_CYCLES - 1))
    else $error("filter accepted early");

  a_filter_quiet: assert property (gate_s2 == gate_filt |=> gate_cnt == 7'h00)
    else $error("filter did not restart");

  a_shift_enable: assert property (slave_norm && !cs_s2 |=> RX_SHIFT_EN)
    else $error("receive shifting not enabled");

endmodule // tgpa_pins
`default_nettype wire

// ===== verification/tgpa_host.sv
// Host model driving the gate, level, chip select and frame inputs
`timescale 1ns/1ns
`default_nettype none
module tgpa_host (
  input  wire logic                  CLK,
  output var  logic                  GATE,
  output var  logic                  LEVEL,
  output var  logic                  CS_N,
  output var  tgpa_pkg::tgpa_frame_t FRAME
);
  // Idle host: gate high, chip select off
  initial begin
    GATE = 1'b1;
    LEVEL = 1'b1;
    CS_N = 1'b1;
    FRAME = '0;
  end
  // new pin levels, held past filter and setup
  task automatic pin(input logic g, input logic l);
    @(negedge CLK);
    GATE = g;
    LEVEL = l;
    repeat (70) @(negedge CLK);
  endtask
  // levels set before supply, no filter wait
  task automatic strap(input logic g, input logic l);
    @(negedge CLK);
    GATE = g;
    LEVEL = l;
  endtask
  // chip select falls with the pins settled
  task automatic select();
    @(negedge CLK);
    CS_N = 1'b1;
    repeat (3) @(negedge CLK);
    CS_N = 1'b0;
    repeat (5) @(negedge CLK);
  endtask
  // one frame, valid for a single cycle
  task automatic send(input logic [63:0] d);
    FRAME = {1'b1, d};
    @(negedge CLK);
    FRAME = '0;
  endtask
endmodule // tgpa_host
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench for the gate, phase and amplitude pin block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                     CLK = 1'b0;
  logic                     RST_N = 1'b0;
  logic                     role = 1'b0;
  tgpa_pkg::tgpa_state_t    st = tgpa_pkg::TGPA_POWERUP;
  tgpa_pkg::tgpa_link_evt_t evt = '0;
  logic                     gate, level, cs_n;
  tgpa_pkg::tgpa_frame_t    frame, push;
  logic                     shift, master, phase, glat, pull, txl;
  int                       n_errors = 0;
  int                       checked = 0;
  // 100 MHz clock
  always #5 CLK = ~CLK;
  tgpa_host tgpa_host_inst (.CLK(CLK), .GATE(gate), .LEVEL(level), .CS_N(cs_n),
    .FRAME(frame));
  tgpa_pins tgpa_pins_inst (.CLK(CLK), .RST_N(RST_N), .DEV_STATE(st),
    .ROLE_SELECT_PIN(role), .GATE_PHASE_PIN(gate), .TX_LEVEL_SELECT_PIN(level),
    .CHIP_SELECT_N(cs_n), .SERIAL_FRAME(frame), .LINK_EVT(evt), .TX_QUEUE_PUSH(push),
    .RX_SHIFT_EN(shift), .MASTER_ROLE(master), .CLOCK_PHASE(phase),
    .GATE_LATCHED(glat), .GATE_PULLUP_EN(pull), .TX_LEVEL(txl));
  task automatic chk(input string nm, input logic [64:0] got, input logic [64:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // Link transmitter event pulse, then time for it to apply
  task automatic link(input logic s, input logic d);
    evt = {s, d};
    cyc(1);
    evt = '0;
    cyc(3);
  endtask
  // Reset, power-up with level pin high, then strap latch
  task automatic boot(input logic r, input logic g);
    RST_N = 1'b0;
    st = tgpa_pkg::TGPA_POWERUP;
    role = r;
    tgpa_host_inst.strap(g, 1'b1);
    cyc(4);
    chk("glat_rst", glat, 1'b1);
    chk("txl_rst", txl, 1'b0);
    RST_N = 1'b1;
    cyc(70);
    chk("txl_pwr", txl, 1'b1);
    st = tgpa_pkg::TGPA_CONFIG;
    cyc(5);
    chk("master", master, r);
    chk("phase", phase, r & g);
    chk("pull_cfg", pull, 1'b1);
    st = tgpa_pkg::TGPA_NORMAL;
  endtask
  task automatic t_push();
    tgpa_host_inst.select();
    chk("glat_hi", glat, 1'b1);
    chk("pull_nrm", pull, 1'b1);
    tgpa_host_inst.send(64'h0123456789abcdef);
    chk("push", push, {1'b1, 64'h0123456789abcdef});
    cyc(1);
    chk("push_once", push, 65'h0);
    $display("Test push done");
  endtask
  task automatic t_gate_low();
    tgpa_host_inst.pin(1'b0, 1'b1);
    tgpa_host_inst.select();
    chk("glat_lo", glat, 1'b0);
    chk("shift", shift, 1'b1);
    tgpa_host_inst.send(64'h00000000000000a5);
    chk("push_lo", push, 65'h0);
    tgpa_host_inst.pin(1'b1, 1'b1);
    chk("glat_kept", glat, 1'b0);
    tgpa_host_inst.send(64'h5a00000000000000);
    chk("push_kept", push, 65'h0);
    $display("Test gate low done");
  endtask
  task automatic t_level();
    tgpa_host_inst.pin(1'b1, 1'b0);
    tgpa_host_inst.select();
    tgpa_host_inst.pin(1'b1, 1'b1);
    tgpa_host_inst.select();
    tgpa_host_inst.pin(1'b1, 1'b0);
    chk("lvl_wait", txl, 1'b1);
    link(1'b1, 1'b0);
    chk("lvl_start", txl, 1'b1);
    link(1'b0, 1'b1);
    chk("lvl_last", txl, 1'b1);
    tgpa_host_inst.select();
    chk("lvl_hold", txl, 1'b1);
    link(1'b0, 1'b1);
    chk("lvl_low", txl, 1'b0);
    $display("Test level slave done");
  endtask
  task automatic t_standby();
    st = tgpa_pkg::TGPA_STANDBY;
    tgpa_host_inst.pin(1'b1, 1'b1);
    chk("pull_sby", pull, 1'b0);
    chk("lvl_sby", txl, 1'b0);
    st = tgpa_pkg::TGPA_WAKEUP;
    cyc(3);
    chk("lvl_wake", txl, 1'b1);
    st = tgpa_pkg::TGPA_NORMAL;
    link(1'b0, 1'b1);
    chk("pull_wake", pull, 1'b1);
    chk("lvl_woken", txl, 1'b1);
    $display("Test standby done");
  endtask
  task automatic t_master();
    boot(1'b1, 1'b1);
    tgpa_host_inst.pin(1'b0, 1'b0);
    chk("phase_kept", phase, 1'b1);
    tgpa_host_inst.select();
    chk("glat_m", glat, 1'b1);
    tgpa_host_inst.send(64'h00000000000000ff);
    chk("push_m", push, 65'h0);
    chk("lvl_m", txl, 1'b1);
    link(1'b1, 1'b0);
    chk("lvl_m_start", txl, 1'b0);
    boot(1'b1, 1'b0);
    chk("phase0", phase, 1'b0);
    $display("Test master done");
  endtask
  // Main sequence
  initial begin
    boot(1'b0, 1'b1);
    t_push();
    t_gate_low();
    t_level();
    t_standby();
    t_master();
    summarize();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
